// ---- hdl/fsp_pkg.sv ----
// Purpose: Shared constants and types for the flash status poller
// Assumes: 10 MHz system clock, byte-wide parallel flash on the pins
// Notes: Offsets are byte addresses of 32-bit APB words
package fsp_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_NS = 100;
  localparam int T_RC_NS = 70;
  localparam int T_WP_NS = 35;
  localparam int RD_CYC = (T_RC_NS + CLK_NS - 1) / CLK_NS;
  localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int SYNC_STAGES = 2;

  // ==========================================================
  // Register map
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_WDATA = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;

  // CTRL fields
  localparam int CTRL_GO = 0;
  localparam int CTRL_OP_LO = 1;
  localparam int CTRL_USE_DQ2 = 3;
  localparam int CTRL_ABORT = 4;

  // STATUS fields
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_OK = 2;
  localparam int ST_FAIL = 3;
  localparam int ST_PRE3 = 4;
  localparam int ST_POST3 = 5;
  localparam int ST_TOG6 = 6;
  localparam int ST_TOG2 = 7;
  localparam int ST_DATA_LO = 8;

  // Data bit positions of the status byte
  localparam int DQ_TOG2 = 2;
  localparam int DQ_TIMER = 3;
  localparam int DQ_LIMIT = 5;
  localparam int DQ_TOG6 = 6;

  // Flash reset command byte (arbitrary value, fixed localparam, not overridable)
  localparam logic [7:0] RESET_CMD = 8'hF0;

  // Operations
  typedef enum logic [1:0] {
    OP_READ = 2'h0,
    OP_WRITE = 2'h1,
    OP_POLL = 2'h2,
    OP_SECADD = 2'h3
  } op_t;

  // Pin bundle driven towards the flash
  typedef struct packed {
    logic [18:0] addr;
    logic [7:0] dq_o;
    logic dq_oe;
    logic ce_n;
    logic oe_n;
    logic we_n;
  } flash_pins_t;

endpackage

// ---- hdl/flash_cycle.sv ----
// Purpose: One asynchronous read or write cycle on the flash pins
// Assumes: Data input already passed two synchroniser flops
// Notes: Every read toggles both chip and output enable
`timescale 1ns/100ps
module flash_cycle #(
  parameter int RD_HOLD = fsp_pkg::RD_CYC + fsp_pkg::SYNC_STAGES,
  parameter int WR_HOLD = fsp_pkg::WP_CYC
) (
  // Clock, reset, enable
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_clk_en,
  // Request
  input wire logic i_start,
  input wire logic i_wr,
  input wire logic [18:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] i_dq_sync,
  // Answer
  output fsp_pkg::flash_pins_t o_pins,
  output logic o_done,
  output logic [7:0] o_rdata
);

  typedef enum logic [1:0] {C_IDLE = 2'h0, C_ACT = 2'h1, C_REC = 2'h3} cst_t;

  cst_t st_r;
  logic [3:0] cnt_r;
  logic wr_r;

  // ==========================================================
  // Cycle sequencer; rec state ends each access with all strobes high
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r <= C_IDLE;
      cnt_r <= 4'h0;
      wr_r <= 1'b0;
      o_done <= 1'b0;
      o_rdata <= 8'h00;
      o_pins <= '{addr: 19'h00000, dq_o: 8'h00, dq_oe: 1'b0,
                  ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
    end else if (i_clk_en) begin
      o_done <= 1'b0;
      case (st_r)
        C_IDLE: begin
          if (i_start) begin
            st_r <= C_ACT;
            wr_r <= i_wr;
            cnt_r <= 4'h1;
            o_pins.addr <= i_addr;
            o_pins.dq_o <= i_wdata;
            o_pins.dq_oe <= i_wr;
            o_pins.ce_n <= 1'b0;
            o_pins.oe_n <= i_wr;
            o_pins.we_n <= !i_wr;
          end
        end
        C_ACT: begin
          if (cnt_r >= (wr_r ? 4'(WR_HOLD) : 4'(RD_HOLD))) begin
            st_r <= C_REC;
            o_rdata <= i_dq_sync;
            o_pins.ce_n <= 1'b1;
            o_pins.oe_n <= 1'b1;
            o_pins.we_n <= 1'b1;
            o_pins.dq_oe <= 1'b0;
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        C_REC: begin
          st_r <= C_IDLE;
          o_done <= 1'b1;
        end
        default: st_r <= C_IDLE;
      endcase
    end
  end

endmodule // flash_cycle

// ---- hdl/flash_poller.sv ----
// Purpose: Host controller that drives a parallel flash and polls status
// Assumes: APB slave on i_sys_clk; flash data pins are asynchronous
// Notes: Software starts one operation at a time through CTRL
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/100ps
module flash_poller (
  // Clock, reset, enable
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_clk_en,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Flash pins
  input wire logic [7:0] i_dq,
  output fsp_pkg::flash_pins_t o_flash
);

  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_RDA = 4'h1, S_RDB = 4'h3, S_CMP1 = 4'h2,
    S_RDC = 4'h6, S_RDD = 4'h7, S_CMP2 = 4'h5, S_RST = 4'h4,
    S_FIN = 4'hC, S_S3A = 4'hD, S_S3W = 4'hF, S_S3B = 4'hE,
    S_ONE = 4'h8
  } st_t;

  st_t st_r, st_nxt;
  fsp_pkg::op_t op_r;
  logic [18:0] addr_r;
  logic [7:0] wdata_r, rd_a_r, rd_b_r, last_r;
  logic [7:0] dq_s1_r, dq_s2_r;
  logic use_dq2_r, pend_r, done_r, ok_r, fail_r;
  logic pre3_r, post3_r, tog6_r, tog2_r;
  logic [3:0] nreads_r;
  logic eng_start, eng_wr, eng_done, acc, tog, busy;
  logic [7:0] eng_wdata, eng_rdata;
  logic apb_acc, apb_wr_go, apb_abort, abort_r, abort_req;
  int sel;

  // ==========================================================
  // Pin synchroniser for the data bus
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      dq_s1_r <= 8'h00;
      dq_s2_r <= 8'h00;
    end else if (i_clk_en) begin
      dq_s1_r <= i_dq;
      dq_s2_r <= dq_s1_r;
    end
  end

  // ==========================================================
  // Cycle engine requests
  assign busy = (st_r != S_IDLE);
  assign acc = (st_r inside {S_RDA, S_RDB, S_RDC, S_RDD, S_RST,
                             S_S3A, S_S3W, S_S3B, S_ONE});
  assign eng_start = acc && !pend_r;
  assign eng_wr = (st_r == S_RST) || (st_r == S_S3W) ||
                  (st_r == S_ONE && op_r == fsp_pkg::OP_WRITE);
  assign eng_wdata = (st_r == S_RST) ? fsp_pkg::RESET_CMD : wdata_r;
  assign sel = use_dq2_r ? fsp_pkg::DQ_TOG2 : fsp_pkg::DQ_TOG6;
  assign tog = rd_a_r[sel] ^ rd_b_r[sel];

  flash_cycle u_cycle (
    .i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst),
    .i_clk_en(i_clk_en),
    .i_start(eng_start),
    .i_wr(eng_wr),
    .i_addr(addr_r),
    .i_wdata(eng_wdata),
    .i_dq_sync(dq_s2_r),
    .o_pins(o_flash),
    .o_done(eng_done),
    .o_rdata(eng_rdata)
  );

  // ==========================================================
  // APB decode
  assign apb_acc = i_psel && i_penable && !o_pready;
  assign apb_wr_go = apb_acc && i_pwrite && (i_paddr == fsp_pkg::OFS_CTRL);
  assign apb_abort = apb_wr_go && i_pwdata[fsp_pkg::CTRL_ABORT];
  // Abort seen now or held until the running cycle ends
  assign abort_req = apb_abort || abort_r;

  // ==========================================================
  // Sequencer next state
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      S_IDLE: begin
        if (apb_wr_go && i_pwdata[fsp_pkg::CTRL_GO] && !apb_abort) begin
          case (fsp_pkg::op_t'(i_pwdata[fsp_pkg::CTRL_OP_LO +: 2]))
            fsp_pkg::OP_POLL: st_nxt = S_RDA;
            fsp_pkg::OP_SECADD: st_nxt = S_S3A;
            default: st_nxt = S_ONE;
          endcase
        end
      end
      S_RDA: if (eng_done) st_nxt = S_RDB;
      S_RDB: if (eng_done) st_nxt = S_CMP1;
      S_CMP1: begin
        if (!tog) st_nxt = S_FIN;
        else if (rd_b_r[fsp_pkg::DQ_LIMIT]) st_nxt = S_RDC;
        else st_nxt = S_RDA;
      end
      S_RDC: if (eng_done) st_nxt = S_RDD;
      S_RDD: if (eng_done) st_nxt = S_CMP2;
      S_CMP2: st_nxt = tog ? S_RST : S_FIN;
      S_RST: if (eng_done) st_nxt = S_FIN;
      S_S3A: begin
        if (eng_done) st_nxt = eng_rdata[fsp_pkg::DQ_TIMER] ? S_FIN : S_S3W;
      end
      S_S3W: if (eng_done) st_nxt = S_S3B;
      S_S3B: if (eng_done) st_nxt = S_FIN;
      S_ONE: if (eng_done) st_nxt = S_FIN;
      S_FIN: st_nxt = S_IDLE;
      default: st_nxt = S_IDLE;
    endcase
    if (abort_req && busy && !acc) st_nxt = S_IDLE;
    if (abort_req && busy && acc && eng_done) st_nxt = S_IDLE;
  end

  // ==========================================================
  // State register and engine handshake
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r <= S_IDLE;
      pend_r <= 1'b0;
      abort_r <= 1'b0;
    end else if (i_clk_en) begin
      st_r <= st_nxt;
      if (st_nxt == S_IDLE) abort_r <= 1'b0;
      else if (apb_abort && busy) abort_r <= 1'b1;
      if (eng_start) pend_r <= 1'b1;
      else if (eng_done) pend_r <= 1'b0;
    end
  end

  // ==========================================================
  // Operands, captured reads and outcome flags
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      op_r <= fsp_pkg::OP_READ;
      addr_r <= 19'h00000;
      wdata_r <= 8'h00;
      use_dq2_r <= 1'b0;
      rd_a_r <= 8'h00;
      rd_b_r <= 8'h00;
      last_r <= 8'h00;
      {done_r, ok_r, fail_r, pre3_r, post3_r, tog6_r, tog2_r} <= 7'h00;
      nreads_r <= 4'h0;
    end else if (i_clk_en) begin
      if (apb_acc && i_pwrite && !busy) begin
        if (i_paddr == fsp_pkg::OFS_ADDR) addr_r <= i_pwdata[18:0];
        if (i_paddr == fsp_pkg::OFS_WDATA) wdata_r <= i_pwdata[7:0];
      end
      if (st_r == S_IDLE && st_nxt != S_IDLE) begin
        op_r <= fsp_pkg::op_t'(i_pwdata[fsp_pkg::CTRL_OP_LO +: 2]);
        use_dq2_r <= i_pwdata[fsp_pkg::CTRL_USE_DQ2];
        {done_r, ok_r, fail_r, pre3_r, post3_r} <= 5'h00;
        nreads_r <= 4'h0;
      end
      // Status byte shows the last read only, never a write cycle
      if (eng_done && !eng_wr) begin
        last_r <= eng_rdata;
        if (nreads_r != 4'hF) nreads_r <= nreads_r + 4'h1;
      end
      if (eng_done && (st_r == S_RDA || st_r == S_RDC)) rd_a_r <= eng_rdata;
      if (eng_done && (st_r == S_RDB || st_r == S_RDD)) rd_b_r <= eng_rdata;
      if (st_r == S_CMP1) begin
        tog6_r <= rd_a_r[fsp_pkg::DQ_TOG6] ^ rd_b_r[fsp_pkg::DQ_TOG6];
        tog2_r <= rd_a_r[fsp_pkg::DQ_TOG2] ^ rd_b_r[fsp_pkg::DQ_TOG2];
      end
      if (st_r == S_CMP1 && !tog) ok_r <= 1'b1;
      if (st_r == S_CMP2 && !tog) ok_r <= 1'b1;
      if (st_r == S_CMP2 && tog) fail_r <= 1'b1;
      if (st_r == S_S3A && eng_done) begin
        pre3_r <= eng_rdata[fsp_pkg::DQ_TIMER];
      end
      if (st_r == S_S3B && eng_done) begin
        post3_r <= eng_rdata[fsp_pkg::DQ_TIMER];
      end
      if (st_r == S_ONE && eng_done) ok_r <= 1'b1;
      if (st_r == S_FIN) done_r <= 1'b1;
    end
  end

  // ==========================================================
  // APB answer: one wait state, registered data
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h00000000;
    end else if (i_clk_en) begin
      o_pready <= apb_acc;
      o_pslverr <= apb_acc && !(i_paddr inside {fsp_pkg::OFS_CTRL,
        fsp_pkg::OFS_ADDR, fsp_pkg::OFS_WDATA, fsp_pkg::OFS_STATUS});
      o_prdata <= 32'h00000000;
      if (apb_acc && !i_pwrite) begin
        case (i_paddr)
          fsp_pkg::OFS_CTRL: begin
            o_prdata[fsp_pkg::CTRL_OP_LO +: 2] <= op_r;
            o_prdata[fsp_pkg::CTRL_USE_DQ2] <= use_dq2_r;
          end
          fsp_pkg::OFS_ADDR: o_prdata[18:0] <= addr_r;
          fsp_pkg::OFS_WDATA: o_prdata[7:0] <= wdata_r;
          fsp_pkg::OFS_STATUS: begin
            o_prdata[fsp_pkg::ST_BUSY] <= busy;
            o_prdata[fsp_pkg::ST_DONE] <= done_r;
            o_prdata[fsp_pkg::ST_OK] <= ok_r;
            o_prdata[fsp_pkg::ST_FAIL] <= fail_r;
            o_prdata[fsp_pkg::ST_PRE3] <= pre3_r;
            o_prdata[fsp_pkg::ST_POST3] <= post3_r;
            o_prdata[fsp_pkg::ST_TOG6] <= tog6_r;
            o_prdata[fsp_pkg::ST_TOG2] <= tog2_r;
            o_prdata[fsp_pkg::ST_DATA_LO +: 8] <= last_r;
          end
          default: o_prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ==========================================================
  // Assertions
  property p_two_reads;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    (st_r == S_CMP1) |-> (nreads_r >= 4'h2);
  endproperty
  a_two_reads: assert property (p_two_reads)
    else $error("verdict taken before two status reads");

  property p_done_stop;
    @(posedge i_sys_clk) disable iff (!i_nrst || !i_clk_en)
    (st_r == S_CMP1 && !tog && !abort_req)
      |=> (st_r == S_FIN && ok_r) ##1 done_r;
  endproperty
  a_done_stop: assert property (p_done_stop)
    else $error("static toggle bit did not end the poll");

  property p_recheck;
    @(posedge i_sys_clk) disable iff (!i_nrst || !i_clk_en)
    (st_r == S_CMP1 && tog && rd_b_r[fsp_pkg::DQ_LIMIT] && !abort_req)
      |=> (st_r == S_RDC);
  endproperty
  a_recheck: assert property (p_recheck)
    else $error("limit bit high without toggle recheck");

  property p_fail_reset;
    @(posedge i_sys_clk) disable iff (!i_nrst || !i_clk_en)
    (st_r == S_CMP2 && tog && !abort_req) |=> (st_r == S_RST) ##[1:20]
      (o_flash.we_n == 1'b0 && o_flash.dq_o == fsp_pkg::RESET_CMD);
  endproperty
  a_fail_reset: assert property (p_fail_reset)
    else $error("failure not followed by reset command write");

  property p_rst_data;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    (st_r == S_RST && eng_start)
      |-> (eng_wr && eng_wdata == fsp_pkg::RESET_CMD);
  endproperty
  a_rst_data: assert property (p_rst_data)
    else $error("reset state issued wrong cycle");

  property p_abort_restart;
    @(posedge i_sys_clk) disable iff (!i_nrst || !i_clk_en)
    (st_r == S_IDLE && st_nxt == S_RDA) |=> (nreads_r == 4'h0);
  endproperty
  a_abort_restart: assert property (p_abort_restart)
    else $error("poll did not restart from first read");

  property p_valid_addr;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    (busy && !o_flash.ce_n) |-> (o_flash.addr == addr_r);
  endproperty
  a_valid_addr: assert property (p_valid_addr)
    else $error("status read on address other than target");

  property p_pre_check;
    @(posedge i_sys_clk) disable iff (!i_nrst || !i_clk_en)
    (st_r == S_S3A && eng_done && eng_rdata[fsp_pkg::DQ_TIMER] &&
      !abort_req)
      |=> (st_r == S_FIN && pre3_r) ##1 (o_flash.we_n == 1'b1);
  endproperty
  a_pre_check: assert property (p_pre_check)
    else $error("sector add written after timer expired");

  property p_tog_flags;
    @(posedge i_sys_clk) disable iff (!i_nrst || !i_clk_en)
    (st_r == S_CMP1) |=> (tog2_r == ($past(rd_a_r[fsp_pkg::DQ_TOG2]) ^
      $past(rd_b_r[fsp_pkg::DQ_TOG2])));
  endproperty
  a_tog_flags: assert property (p_tog_flags)
    else $error("bit 2 toggle flag wrong");

endmodule // flash_poller

// ---- verif/flash_model.sv ----
// Purpose: Behavioural flash that answers the poller with status bytes
// Assumes: A read ends when chip or output enable rises
// Notes: Busy length and erase time-out are counted in status reads
`timescale 1ns/100ps
module flash_model (
  // Pins
  input wire fsp_pkg::flash_pins_t i_pins,
  input wire logic [7:0] i_dq,
  // Scenario setup
  input wire logic i_load,
  input wire logic i_erase,
  input wire logic i_stuck,
  input wire logic [7:0] i_busy,
  input wire logic [7:0] i_tmr,
  input wire logic [7:0] i_array,
  // Outputs
  output logic [7:0] o_dq,
  output logic [7:0] o_wdata
);
  logic rd_act, wr_act, busy;
  logic tog = 1'b0;
  logic stuck = 1'b0;
  logic [7:0] stat, wbuf;
  logic [7:0] last = 8'h00;
  int left = 0;
  int tmr = 0;
  int tmr_ld = 0;
  // ==========================================================
  // Status byte, and the inverted last byte driven when not read
  assign rd_act = !i_pins.ce_n && !i_pins.oe_n;
  assign wr_act = !i_pins.ce_n && !i_pins.we_n;
  assign busy = stuck || left > 0;
  assign stat = {i_erase ? 1'b0 : ~i_array[7], tog, stuck,
    i_erase && tmr == 0, 1'b0, i_erase && tog, 2'b00};
  assign o_dq = rd_act ? (busy ? stat : i_array) : ~last;
  // Scenario load
  always @(posedge i_load) begin
    left = i_busy;
    tmr = i_tmr;
    tmr_ld = i_tmr;
    stuck = i_stuck;
  end
  // One read per enable-bounded cycle
  always @(negedge rd_act) begin
    if ($time > 0) begin
      last = busy ? stat : i_array;
      if (busy) begin
        tog = ~tog;
        if (left > 0) left--;
        if (tmr > 0) tmr--;
      end
    end
  end
  // Write capture
  always @(posedge wr_act) begin
    #1 wbuf = i_dq;
  end
  always @(negedge wr_act) begin
    if ($time > 0) begin
      o_wdata = wbuf;
      if (wbuf == fsp_pkg::RESET_CMD) begin
        left = 0;
        stuck = 0;
      end else if (busy && tmr > 0) begin
        tmr = tmr_ld;
      end
    end
  end
endmodule // flash_model

// ---- verif/flash_poller_test.sv ----
// Purpose: Self-checking bench for the flash status poller
// Assumes: APB master in bench, behavioural flash beside the pins
// Notes: Expected status comes from an integer model of the flash
`timescale 1ns/100ps
module flash_poller_test;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, e;
  logic load = 1'b0;
  logic erase = 1'b0;
  logic stuck = 1'b0;
  logic [7:0] busy_n = 8'h00;
  logic [7:0] tmr = 8'h00;
  logic [7:0] arr = 8'h00;
  logic [7:0] m_dq, m_wdata, wd, dq;
  fsp_pkg::flash_pins_t flash;
  int seed = 32'h2217B379;
  int miscompares = 0;
  int cmp_count = 0;
  int b_left, b_tmr, b_tld, k;
  logic b_tog = 1'b0;
  logic b_stuck = 1'b0;
  logic [15:0] s;
  int pe[6] = '{0, 1, 0, 1, 0, 1};
  int ps[6] = '{0, 0, 0, 1, 1, 0};
  int pn[6] = '{5, 7, 6, 0, 0, 1};
  int pu[6] = '{0, 1, 1, 0, 1, 0};
  int ta[3] = '{0, 3, 1};
  // ==========================================================
  // Clock, wire and instances
  always #50 sys_clk = ~sys_clk;
  assign dq = flash.dq_oe ? flash.dq_o : m_dq;
  flash_poller i_dut (.i_sys_clk(sys_clk), .i_nrst(nrst), .i_clk_en(1'b1),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_dq(dq), .o_flash(flash));
  flash_model i_flash (.i_pins(flash), .i_dq(dq), .i_load(load),
    .i_erase(erase), .i_stuck(stuck), .i_busy(busy_n), .i_tmr(tmr),
    .i_array(arr), .o_dq(m_dq), .o_wdata(m_wdata));
  // ==========================================================
  // Checking and bus tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic run(input logic [1:0] o, input logic u2);
    apb(1'b1, fsp_pkg::OFS_CTRL, {27'h0, 1'b0, u2, o, 1'b1});
    for (k = 0; k < 400; k++) begin
      apb(1'b0, fsp_pkg::OFS_STATUS, 32'h0);
      if (q[fsp_pkg::ST_BUSY] === 1'b0) break;
    end
  endtask
  // ==========================================================
  // Integer flash model
  task automatic setup(input logic ee, input logic ss, input int n, t);
    @(posedge sys_clk);
    erase <= ee;
    stuck <= ss;
    busy_n <= n[7:0];
    tmr <= t[7:0];
    arr <= 8'($random(seed));
    load <= 1'b1;
    @(posedge sys_clk);
    load <= 1'b0;
    b_left = n;
    b_tmr = t;
    b_tld = t;
    b_stuck = ss;
    apb(1'b1, fsp_pkg::OFS_ADDR, $random(seed));
  endtask
  function automatic logic [7:0] b_rd();
    logic [7:0] v;
    v = arr;
    if (b_stuck || b_left > 0) begin
      v = {erase ? 1'b0 : ~arr[7], b_tog, b_stuck, erase && b_tmr == 0,
           1'b0, erase && b_tog, 2'b00};
      b_tog = ~b_tog;
      if (b_left > 0) b_left--;
      if (b_tmr > 0) b_tmr--;
    end
    return v;
  endfunction
  function automatic void b_wr(input logic [7:0] d);
    if (d == fsp_pkg::RESET_CMD) begin
      b_left = 0;
      b_stuck = 1'b0;
    end else if ((b_stuck || b_left > 0) && b_tmr > 0) b_tmr = b_tld;
  endfunction
  function automatic logic [15:0] exp_poll(input int i);
    logic [7:0] a, b;
    logic [15:0] r;
    int j;
    r = 16'h0002;
    for (j = 0; j < 64; j++) begin
      a = b_rd();
      b = b_rd();
      r[15:8] = b;
      if (a[i] == b[i]) return r | 16'h0004;
      if (b[5]) begin
        a = b_rd();
        b = b_rd();
        r[15:8] = b;
        if (a[i] == b[i]) return r | 16'h0004;
        b_wr(fsp_pkg::RESET_CMD);
        return r | 16'h0008;
      end
    end
    return r;
  endfunction
  // ==========================================================
  // Scenarios
  initial begin
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    apb(1'b0, fsp_pkg::OFS_STATUS, 32'h0);
    check(q, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    check({e, q}, {1'b1, 32'h0});
    apb(1'b1, 8'h14, 32'h5);
    check(e, 1'b1);
    run(fsp_pkg::OP_SECADD, 1'b1);
    apb(1'b0, fsp_pkg::OFS_CTRL, 32'h0);
    check(q, 32'hE);
    for (int i = 0; i < 6; i++) begin
      setup(pe[i], ps[i], pn[i], 0);
      run(fsp_pkg::OP_POLL, pu[i][0]);
      s = exp_poll(pu[i] != 0 ? 2 : 6);
      check(q & 32'hFF0F, {16'h0, s});
      if (ps[i] != 0) check(m_wdata, fsp_pkg::RESET_CMD);
    end
    for (int i = 0; i < 3; i++) begin
      setup(1'b1, 1'b0, 50, ta[i]);
      wd = 8'($random(seed)) & 8'h7F;
      apb(1'b1, fsp_pkg::OFS_WDATA, {24'h0, wd});
      run(fsp_pkg::OP_SECADD, 1'b0);
      s = 16'h0002;
      if (b_rd() & 8'h08) s[4] = 1'b1;
      else begin
        b_wr(wd);
        wd = b_rd();
        s[5] = wd[fsp_pkg::DQ_TIMER];
      end
      check(q & 32'h33, {16'h0, s});
    end
    setup(1'b0, 1'b0, 0, 0);
    wd = 8'($random(seed)) & 8'h7F;
    apb(1'b1, fsp_pkg::OFS_WDATA, {24'h0, wd});
    run(fsp_pkg::OP_WRITE, 1'b0);
    check(m_wdata, wd);
    run(fsp_pkg::OP_READ, 1'b0);
    check(q & 32'hFF03, {16'h0, b_rd(), 8'h02});
    setup(1'b0, 1'b0, 200, 0);
    apb(1'b1, fsp_pkg::OFS_CTRL, 32'h5);
    repeat (30) @(posedge sys_clk);
    apb(1'b1, fsp_pkg::OFS_CTRL, 32'h10);
    repeat (8) @(posedge sys_clk);
    apb(1'b0, fsp_pkg::OFS_STATUS, 32'h0);
    check(q[fsp_pkg::ST_BUSY], 1'b0);
    run(fsp_pkg::OP_POLL, 1'b0);
    check(q[fsp_pkg::ST_BUSY], 1'b0);
    check(q[fsp_pkg::ST_OK], 1'b1);
    complete_run();
  end
  // Watchdog
  initial begin
    #5000000;
    miscompares++;
    complete_run();
  end
endmodule // flash_poller_test
